// ===== design/vamc_pkg.sv
// Constants and types for the voltage and thermal ADC mode control block.
// Assumes a 10 MHz system clock and an external analog front end.
package vamc_pkg;

    // =========================================
    // Register offsets and field positions
    localparam logic [7:0] ADDR_RESULT_BASE = 8'h20;
    localparam logic [7:0] ADDR_ADC_CONFIG_ONE = 8'h40;
    localparam logic [7:0] ADDR_FAN1_MIN_HIGH_AND_CHANNEL_SELECT = 8'h55;
    localparam logic [7:0] ADDR_ADC_CONFIG_TWO = 8'h73;
    localparam int CFG1_SUPPLY_5V_BIT = 7;
    localparam int CFG2_AVG_OFF_BIT = 4;
    localparam int CFG2_ATTEN_BYPASS_BIT = 5;
    localparam int CFG2_SINGLE_CHAN_BIT = 6;
    localparam int CHAN_SEL_MSB = 7;
    localparam int CHAN_SEL_LSB = 5;

    // =========================================
    // Reset values
    localparam logic [7:0] RST_ADC_CONFIG_ONE = 8'h00;
    localparam logic [7:0] RST_ADC_CONFIG_TWO = 8'h00;
    localparam logic [7:0] RST_FAN1_MIN_HIGH = 8'h00;
    localparam logic [9:0] RST_RESULT = 10'h000;

    // =========================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 700000;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int AVG_COUNT = 16;
    localparam int MEAS_TIME_NS = 11000000;

    // =========================================
    // Converter codes
    localparam logic [9:0] CODE_MAX = 10'h3FF;
    localparam logic [9:0] CODE_NOMINAL = 10'h300;

    // =========================================
    // Channel and bias encodings
    typedef enum logic [2:0] {
        CH_IN_2V5 = 3'h0,
        CH_PROCESSOR_CORE_VOLTAGE = 3'h1,
        CH_SUPPLY = 3'h2,
        CH_IN_5V = 3'h3,
        CH_IN_12V = 3'h4,
        CH_REMOTE1_TEMP = 3'h5,
        CH_LOCAL_TEMP = 3'h6,
        CH_REMOTE2_TEMP = 3'h7
    } vamc_chan_type;

    typedef enum logic [1:0] {
        BIAS_I = 2'h0,
        BIAS_N1_I = 2'h1,
        BIAS_N2_I = 2'h2
    } vamc_bias_type;

endpackage : vamc_pkg

// ===== design/vamc_avg.sv
// Sixteen-sample averager for converter codes.
// Assumes one valid sample per conversion from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module vamc_avg
    import vamc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic avg_en,
    input wire logic restart,
    // Samples in
    input wire logic sample_valid,
    input wire logic [9:0] sample,
    // Result out, combinational in the sample cycle
    output logic result_valid,
    output logic [9:0] result
);

    typedef struct packed {
        logic [13:0] acc;
        logic [3:0] cnt;
    } vamc_avg_state_type;

    vamc_avg_state_type s_q;
    vamc_avg_state_type s_d;
    logic [13:0] sum;

    always_comb begin
        s_d = s_q;
        sum = s_q.acc + {4'h0, sample};
        result_valid = 1'b0;
        result = sample;
        if (restart) begin
            s_d.acc = 14'h0000;
            s_d.cnt = 4'h0;
        end else if (sample_valid) begin
            if (!avg_en) begin
                result_valid = 1'b1;
            end else if (s_q.cnt == 4'(AVG_COUNT - 1)) begin
                result_valid = 1'b1;
                result = sum[13:4];
                s_d.acc = 14'h0000;
                s_d.cnt = 4'h0;
            end else begin
                s_d.acc = sum;
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // vamc_avg
`default_nettype wire

// ===== design/vamc_top.sv
// Conversion sequencer and mode registers for the measurement converter.
// Assumes an analog front end that muxes, scales and digitises on request;
// its raw code arrives asynchronously and is resynchronised here.
`timescale 1ns/1ps
`default_nettype none
module vamc_top
    import vamc_pkg::*;
#(
    parameter int CONV_CYCLES_P = CONV_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog front end control
    output logic [2:0] mux_sel,
    output logic atten_bypass,
    output logic supply_5v_scale,
    output logic [1:0] bias_current_sel,
    output logic sample_strobe,
    // Raw signed converter output from the front end
    input wire logic [11:0] adc_raw,
    // Full-width results
    output logic [9:0] result_code [8],
    output logic result_update
);

    typedef struct packed {
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] fan1;
        logic [11:0] raw_s1;
        logic [11:0] raw_s2;
        logic [11:0] raw_s3;
        logic [11:0] raw_hold;
        logic [15:0] timer;
        logic [2:0] chan;
        logic [1:0] bias;
        logic strobe;
        logic update;
        logic [7:0][9:0] res;
        logic [7:0] rdata;
    } vamc_top_state_type;

    localparam logic [15:0] TIMER_LOAD = 16'(CONV_CYCLES_P - 1);
    localparam logic [15:0] PHASE_ONE = 16'((2 * CONV_CYCLES_P) / 3);
    localparam logic [15:0] PHASE_TWO = 16'(CONV_CYCLES_P / 3);

    vamc_top_state_type s_q;
    vamc_top_state_type s_d;
    logic avg_en;
    logic single_mode;
    logic [2:0] sel_chan;
    logic conv_done;
    logic [9:0] clamped;
    logic avg_restart;
    logic wr_cfg1;
    logic wr_cfg2;
    logic wr_fan1;
    logic sel_moved;
    logic avg_valid;
    logic [9:0] avg_result;

    // =========================================
    // Mode decode
    assign avg_en = !s_q.cfg2[CFG2_AVG_OFF_BIT];
    assign single_mode = s_q.cfg2[CFG2_SINGLE_CHAN_BIT];
    assign sel_chan = s_q.fan1[CHAN_SEL_MSB:CHAN_SEL_LSB];
    assign conv_done = (s_q.timer == 16'h0000);

    // =========================================
    // Register write decode
    assign wr_cfg1 = reg_wr && (reg_addr == ADDR_ADC_CONFIG_ONE);
    assign wr_cfg2 = reg_wr && (reg_addr == ADDR_ADC_CONFIG_TWO);
    assign wr_fan1 = reg_wr && (reg_addr == ADDR_FAN1_MIN_HIGH_AND_CHANNEL_SELECT);

    // =========================================
    // Negative raw clamps to zero, overrange to full scale
    always_comb begin
        if (s_q.raw_hold[11]) begin
            clamped = 10'h000;
        end else if (s_q.raw_hold[10]) begin
            clamped = CODE_MAX;
        end else begin
            clamped = s_q.raw_hold[9:0];
        end
    end

    // =========================================
    // Restart averaging when the mode or channel is changed under it.
    // The partial average is thrown away: a fresh result costs one more
    // measurement but never mixes two channels or two modes.
    assign sel_moved = single_mode && (sel_chan != s_q.chan);
    assign avg_restart = wr_cfg2 || sel_moved;

    vamc_avg u_avg (
        .clk(clk),
        .sys_rst(sys_rst),
        .avg_en(avg_en),
        .restart(avg_restart),
        .sample_valid(conv_done),
        .sample(clamped),
        .result_valid(avg_valid),
        .result(avg_result)
    );

    // =========================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.strobe = conv_done;
        s_d.update = 1'b0;

        // =========================================
        // Raw code resynchroniser
        s_d.raw_s1 = adc_raw;
        s_d.raw_s2 = s_q.raw_s1;
        s_d.raw_s3 = s_q.raw_s2;
        // Word taken only when two samples agree, so skewed bits never mix
        if (s_q.raw_s2 == s_q.raw_s3) begin
            s_d.raw_hold = s_q.raw_s2;
        end

        // =========================================
        // Register writes
        if (wr_cfg1) begin
            s_d.cfg1 = reg_wdata;
        end
        if (wr_cfg2) begin
            s_d.cfg2 = reg_wdata;
        end
        if (wr_fan1) begin
            s_d.fan1 = reg_wdata;
        end

        // =========================================
        // Conversion timer and channel step
        if (avg_restart) begin
            // Fresh conversion so no stale partial sample is averaged
            s_d.timer = TIMER_LOAD;
            if (single_mode) begin
                s_d.chan = sel_chan;
            end
        end else if (conv_done) begin
            s_d.timer = TIMER_LOAD;
            if (avg_valid) begin
                s_d.res[s_q.chan] = avg_result;
                s_d.update = 1'b1;
                s_d.chan = single_mode ? sel_chan : s_q.chan + 3'h1;
            end
        end else begin
            s_d.timer = s_q.timer - 16'h0001;
        end

        // =========================================
        // Bias steps, three currents per temperature conversion
        if (s_q.chan >= CH_REMOTE1_TEMP) begin
            if (s_d.timer > PHASE_ONE) begin
                s_d.bias = BIAS_I;
            end else if (s_d.timer > PHASE_TWO) begin
                s_d.bias = BIAS_N1_I;
            end else begin
                s_d.bias = BIAS_N2_I;
            end
        end else begin
            s_d.bias = BIAS_I;
        end

        // =========================================
        // Value registers show the eight most significant bits
        if (reg_addr[7:3] == ADDR_RESULT_BASE[7:3]) begin
            s_d.rdata = s_q.res[reg_addr[2:0]][9:2];
        end else if (reg_addr == ADDR_ADC_CONFIG_ONE) begin
            s_d.rdata = s_q.cfg1;
        end else if (reg_addr == ADDR_ADC_CONFIG_TWO) begin
            s_d.rdata = s_q.cfg2;
        end else if (reg_addr == ADDR_FAN1_MIN_HIGH_AND_CHANNEL_SELECT) begin
            s_d.rdata = s_q.fan1;
        end else begin
            s_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.cfg1 <= RST_ADC_CONFIG_ONE;
            s_q.cfg2 <= RST_ADC_CONFIG_TWO;
            s_q.fan1 <= RST_FAN1_MIN_HIGH;
            s_q.timer <= TIMER_LOAD;
            s_q.chan <= CH_IN_2V5;
            s_q.bias <= BIAS_I;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================
    // Outputs
    assign reg_rdata = s_q.rdata;
    assign mux_sel = s_q.chan;
    assign atten_bypass = s_q.cfg2[CFG2_ATTEN_BYPASS_BIT];
    assign supply_5v_scale = s_q.cfg1[CFG1_SUPPLY_5V_BIT];
    assign bias_current_sel = s_q.bias;
    assign sample_strobe = s_q.strobe;
    assign result_update = s_q.update;

    // =========================================
    // Result array, one flop word per channel
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_res
            assign result_code[g] = s_q.res[g];
        end
    endgenerate

endmodule // vamc_top
`default_nettype wire

// ===== verif/vamc_checker.sv
// Port assertions for the mode control block.
// Assumes binding to vamc_top.
`timescale 1ns/1ps
`default_nettype none
module vamc_checker
    import vamc_pkg::*;
#(
    parameter int CONV_CYCLES_P = CONV_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Registers
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Front end
    input wire logic [2:0] mux_sel,
    input wire logic atten_bypass,
    input wire logic [1:0] bias_current_sel,
    input wire logic sample_strobe,
    input wire logic result_update
);
    logic [7:0] c2_q;
    logic [2:0] sel_q;
    wire w2 = reg_wr && reg_addr == ADDR_ADC_CONFIG_TWO;
    wire w5 = reg_wr && reg_addr == ADDR_FAN1_MIN_HIGH_AND_CHANNEL_SELECT;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c2_q <= 8'h00;
            sel_q <= 3'h0;
        end else begin
            if (w2) c2_q <= reg_wdata;
            if (w5) sel_q <= reg_wdata[7:5];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe [*8])
        else $error("strobes too close");
    update_strobe_a: assert property (result_update |-> sample_strobe)
        else $error("update without strobe");
    bypass_follow_a: assert property (w2 |-> ##2 atten_bypass == $past(reg_wdata[5], 2))
        else $error("bypass not following");
    cfg_read_a: assert property (!reg_wr && reg_addr == ADDR_ADC_CONFIG_TWO |=> reg_rdata == c2_q)
        else $error("config read wrong");
    single_sel_a: assert property (sample_strobe && c2_q[6] && !$past(w2) && !$past(w5)
        |-> mux_sel == sel_q)
        else $error("single channel wrong");
    rr_step_a: assert property (sample_strobe && c2_q[4] && !c2_q[6] && !$past(w2)
        |-> mux_sel == $past(mux_sel) + 3'h1)
        else $error("round robin step wrong");
    bias_volt_a: assert property (mux_sel < 3'h5 |-> bias_current_sel == 2'h0)
        else $error("bias on voltage channel");
    bias_step_a: assert property ($changed(bias_current_sel)
        |-> bias_current_sel == 2'h0 || bias_current_sel == $past(bias_current_sel) + 2'h1)
        else $error("bias step wrong");
    cover property (result_update && c2_q[6]);
    cover property (bias_current_sel == 2'h2);
    cover property (result_update && !c2_q[4]);
    cover property (sample_strobe && c2_q[4] && !c2_q[6]);
endmodule // vamc_checker
bind vamc_top vamc_checker #(.CONV_CYCLES_P(CONV_CYCLES_P)) u_chk (.clk, .sys_rst, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rdata, .mux_sel, .atten_bypass, .bias_current_sel,
    .sample_strobe, .result_update);
`default_nettype wire

// ===== verif/vamc_front_end.sv
// Analog front end model: one raw code per channel.
// Assumes the bench sets the levels.
`timescale 1ns/1ps
`default_nettype none
module vamc_front_end
    import vamc_pkg::*;
(
    // Device control
    input wire logic [2:0] mux_sel,
    input wire logic [1:0] bias_current_sel,
    // Bench levels
    input wire logic [11:0] level [8],
    output logic [11:0] adc_raw
);
    // Temp reading only valid once the bias has reached its last step
    wire bad = mux_sel > 3'h4 && bias_current_sel != 2'h2;
    assign adc_raw = bad ? ~level[mux_sel] : level[mux_sel];
endmodule // vamc_front_end
`default_nettype wire

// ===== verif/vamc_test.sv
// Self-checking bench for vamc_top with a short conversion.
`timescale 1ns/1ps
`default_nettype none
module vamc_test;
    import vamc_pkg::*;
    localparam int CONV = 30;
    logic clk, sys_rst, reg_wr, atten_bypass, supply_5v_scale, sample_strobe, result_update;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] mux_sel;
    logic [1:0] bias_current_sel;
    logic [11:0] adc_raw;
    logic [11:0] level [8];
    logic [9:0] result_code [8];
    logic [31:0] rng = 32'h4347;
    int n_fail = 0, checked = 0, nstr, ncyc, m_chan;
    int m_res [8];
    vamc_top #(.CONV_CYCLES_P(CONV)) dut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata, .mux_sel, .atten_bypass, .supply_5v_scale, .bias_current_sel,
        .sample_strobe, .adc_raw, .result_code, .result_update);
    vamc_front_end u_fe (.mux_sel, .bias_current_sel, .level, .adc_raw);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [9:0] sat(logic [11:0] r);
        if (r[11]) return 10'h000;
        if (r[10]) return 10'h3FF;
        return r[9:0];
    endfunction
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk) #1;
        reg_addr = a;
        @(posedge clk) #1;
        check("reg_rdata", {2'h0, reg_rdata}, {2'h0, e});
    endtask
    task automatic wait_upd(int n);
        ncyc = 0;
        nstr = 0;
        while (n > 0 && ncyc < 5000) begin
            @(posedge clk) #1;
            ncyc++;
            nstr += int'(sample_strobe);
            n -= int'(result_update);
        end
        if (n > 0) check("update wait", 10'h001, 10'h000);
    endtask
    // Config write restarts conversion, then fresh random levels;
    // levels move only after the restart, so no stored result mixes old and new
    task automatic go(logic [7:0] c2);
        wr(ADDR_ADC_CONFIG_TWO, c2);
        for (int i = 0; i < 8; i++) begin
            rng ^= rng << 13;
            rng ^= rng >> 17;
            rng ^= rng << 5;
            level[i] = rng[11:0];
        end
    endtask
    // Reference model: each stored result is the clamped level of the channel just converted
    always @(posedge clk) begin
        #2;
        if (!sys_rst && result_update) begin
            m_res[m_chan] = int'(sat(level[m_chan]));
            check("model result", result_code[m_chan], 10'(m_res[m_chan]));
        end
        m_chan = int'(mux_sel);
    end
    task automatic check_all();
        logic [9:0] e;
        for (int i = 0; i < 8; i++) begin
            e = sat(level[i]);
            check("result_code", result_code[i], e);
            rd(ADDR_RESULT_BASE + 8'(i), e[9:2]);
        end
    endtask
    task automatic final_report();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        final_report();
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, sys_rst} = {17'h0, 1'b1};
        for (int i = 0; i < 8; i++) level[i] = 12'h000;
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        foreach (level[i]) rd(8'h20 + 8'(i), 8'h00);
        rd(8'h10, 8'h00);
        rd(ADDR_ADC_CONFIG_TWO, 8'h00);
        wr(ADDR_ADC_CONFIG_ONE, 8'h80);
        check("supply_5v_scale", {9'h0, supply_5v_scale}, 10'h001);
        rd(ADDR_ADC_CONFIG_ONE, 8'h80);
        go(8'h30);
        check("atten_bypass", {9'h0, atten_bypass}, 10'h001);
        wait_upd(8);
        check("strobes", 10'(nstr), 10'h008);
        check_all();
        go(8'h00);
        check("atten_bypass", {9'h0, atten_bypass}, 10'h000);
        wait_upd(8);
        check_all();
        for (int s = 0; s < 8; s++) begin
            go(8'h50);
            wr(ADDR_FAN1_MIN_HIGH_AND_CHANNEL_SELECT, 8'(s << 5) | 8'h1F);
            wait_upd(1);
            wait_upd(1);
            check("period", 10'(ncyc), 10'(CONV));
            check("mux_sel", 10'(mux_sel), 10'(s));
            check("result_code", result_code[s], sat(level[s]));
            rd(ADDR_FAN1_MIN_HIGH_AND_CHANNEL_SELECT, 8'(s << 5) | 8'h1F);
        end
        go(8'h40);
        wait_upd(1);
        wait_upd(1);
        check("strobes", 10'(nstr), 10'h010);
        check("period", 10'(ncyc), 10'(16 * CONV));
        check("result_code", result_code[7], sat(level[7]));
        final_report();
    end
endmodule // vamc_test
`default_nettype wire
